// *** hdl/cse_map.svh ***
// Offsets, field positions and reset values of the CAN status set
`ifndef CSE_MAP_SVH
`define CSE_MAP_SVH
`define CSE_ADR_GIT      8'h9b
`define CSE_ADR_TEC      8'h9c
`define CSE_ADR_REC      8'h9d
`define CSE_ADR_GSTA     8'haa
`define CSE_ADR_GIE      8'hc1
`define CSE_ADR_EN       8'hcf
`define CSE_GSTA_OVL     6
`define CSE_GSTA_TXA     4
`define CSE_GSTA_RXA     3
`define CSE_GSTA_ACT     2
`define CSE_GSTA_BUS_OFF_STATE    1
`define CSE_GSTA_EPAS    0
`define CSE_GIT_IRQ      7
`define CSE_GIT_TIM      5
`define CSE_GIT_BUF      4
`define CSE_GIE_RX       5
`define CSE_GIE_TX       4
`define CSE_GIE_OBJ      3
`define CSE_GIE_BUF      2
`define CSE_GIE_ERR      1
`define CSE_RST_BYTE     8'h00
`define CSE_RST_CNT      8'h00
`define CSE_EPAS_LIM     8'h7f
`define CSE_WAKE_CYC     2'h2
`define CSE_STUFF_MAX    3'h5
`define CSE_TIM_MAX      16'hffff
`define CSE_TIM_ZERO     16'h0000
`define CSE_CRC_POLY     15'h4599
`define CSE_CRC_INIT     15'h0000
`endif

// *** hdl/cse_pkg.sv ***
// Types shared by the CAN status and error register set
package cse_pkg;
    // Frame activity reported by the protocol engine
    typedef struct packed {
        logic overload_tx; // Own overload frame on the bus
        logic frame_tx;    // Transmitter drives a frame
        logic ack_tx;      // Transmitter drives ack field
        logic ifs;         // Interframe spacing
        logic tx_pending;  // A frame waits to be sent
        logic frame_rx;    // Receiver acquires or monitors
    } cse_act_type;
    // Bit stream taps for the error checks
    typedef struct packed {
        logic raw_vld;     // Raw bus bit sampled
        logic raw_bit;     // Raw bus bit value
        logic stuff_zone;  // Stuffed part of the frame
        logic crc_vld;     // Destuffed bit, SOF to data
        logic crc_bit;     // Destuffed bit value
        logic crcf_vld;    // Bit of received CRC field
        logic crc_done;    // CRC field complete
        logic fixed_fld;   // Delimiter or end of frame bit
        logic ack_slot;    // Ack slot after own frame
    } cse_bits_type;
    // Enable sequencer, Gray along the usual path
    typedef enum logic [1:0] {
        CSE_OFF   = 2'b00,
        CSE_WAKE1 = 2'b01,
        CSE_WAKE2 = 2'b11,
        CSE_RUN   = 2'b10
    } cse_state_type;
endpackage

// *** hdl/cse_status_regs.sv ***
// CAN global status, error flags, counters and irq mask registers
`timescale 1ns/100ps
`include "cse_map.svh"
// What this block does
// - Overload bit high while own overload sent
// - Tx busy bit during any transmitted frame
// - Tx busy also in spacing when pending
// - Rx busy bit while receiving or monitoring
// - Active bit shows real state, not request
// - Bit1 bus off, bit0 error passive
// - Status register is read only
// - Bit7 mirrors combined interrupt request
// - Timer wrap flag on ffff to 0000
// - Timer irq only when enabled, sw clears
// - Buffer flag set when full, sw clears
// - Stuff error on six equal bits
// - Rx CRC mismatch sets CRC error flag
// - Form error in delimiters or EOF
// - Ack error when ack slot recessive
// - Tx error count readable, resets zero
// - Rx error count readable, resets zero
// - Mask bits 5 rx, 4 tx
// - Mask bits 3 object, 2 buffer, 1 error
// - Object enable bits 3 to 0 read only
// - Object bit cleared only by control rewrite or soft reset
// - Two clocks to start after enable
// - Disable waits for frame end, then freeze
module cse_status_regs
    import cse_pkg::*;
(
    input  wire logic         clk_i,        // Controller clock
    input  wire logic         rst_i,        // Async reset, high
    input  wire logic         soft_rst_i,   // General reset pulse
    input  wire logic [7:0]   sfr_addr_i,   // Register address
    input  wire logic         sfr_wr_i,     // Write strobe
    input  wire logic         sfr_rd_i,     // Read strobe
    input  wire logic [7:0]   sfr_wdata_i,  // Write data
    output logic      [7:0]   sfr_rdata_o,  // Read data
    input  wire logic         run_ctl_i,    // Run control level
    input  wire cse_act_type  act_i,        // Frame activity
    input  wire cse_bits_type bits_i,       // Bit stream taps
    input  wire logic [7:0]   tec_i,        // Tx error counter
    input  wire logic [7:0]   rec_i,        // Rx error counter
    input  wire logic         bus_off_i,    // Fault state bus off
    input  wire logic [15:0]  can_timer_i,  // CAN timer value
    input  wire logic         tim_irq_on_i, // Timer wrap irq on
    input  wire logic         buf_full_i,   // Rx buffer full
    input  wire logic         rx_src_i,     // Rx irq source
    input  wire logic         tx_src_i,     // Tx irq source
    input  wire logic         obj_src_i,    // Object error source
    input  wire logic [3:0]   obj_wr_i,     // Object ctrl written
    input  wire logic [3:0]   obj_en_i,     // Written enable value
    output logic              irq_o,        // Combined irq request
    output logic              active_o,     // Engine running
    output logic [3:0]        obj_active_o  // Object enable bits
);

    logic [7:0]    tec_q;
    logic [7:0]    rec_q;
    logic          bus_off_state_q;
    logic          epas_q;
    logic          ovl_q;
    logic          txa_q;
    logic          rxa_q;
    logic          tim_q;
    logic          buf_q;
    logic          stf_q;
    logic          crc_q;
    logic          frm_q;
    logic          ack_q;
    logic [5:1]    gie_q;
    logic [3:0]    obj_q;
    logic          irq_q;
    logic [7:0]    rdata_q;
    logic [15:0]   tim_prev_q;
    logic          buf_prev_q;
    logic [2:0]    run_cnt_q;
    logic          run_bit_q;
    logic [14:0]   crc_calc_q;
    logic [14:0]   crc_rcv_q;
    cse_state_type st_q;
    logic          active_q;
    logic          irq_d;
    logic          wr_git;
    logic          idle;
    logic          tim_ev;
    logic          buf_ev;
    logic          stf_ev;
    logic          crc_ev;
    logic          frm_ev;
    logic          ack_ev;
    logic [14:0]   crc_next;

    // Register writes and frame idle
    assign wr_git = sfr_wr_i && (sfr_addr_i == `CSE_ADR_GIT);
    assign idle   = !(act_i.frame_tx || act_i.ack_tx || act_i.frame_rx
                      || act_i.overload_tx);

    // Busy and overload bits follow the engine, status is read only
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            ovl_q <= 1'b0;
            txa_q <= 1'b0;
            rxa_q <= 1'b0;
        end else if (soft_rst_i) begin
            ovl_q <= 1'b0;
            txa_q <= 1'b0;
            rxa_q <= 1'b0;
        end else begin
            ovl_q <= act_i.overload_tx;
            txa_q <= act_i.frame_tx || act_i.ack_tx
                     || act_i.overload_tx
                     || (act_i.ifs && act_i.tx_pending);
            rxa_q <= act_i.frame_rx;
        end
    end

    // Counters and fault confinement; no software write path
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tec_q  <= `CSE_RST_CNT;
            rec_q  <= `CSE_RST_CNT;
            bus_off_state_q <= 1'b0;
            epas_q <= 1'b0;
        end else if (soft_rst_i) begin
            tec_q  <= `CSE_RST_CNT;
            rec_q  <= `CSE_RST_CNT;
            bus_off_state_q <= 1'b0;
            epas_q <= 1'b0;
        end else begin
            tec_q  <= tec_i;
            rec_q  <= rec_i;
            bus_off_state_q <= bus_off_i;
            epas_q <= !bus_off_i && ((tec_i > `CSE_EPAS_LIM)
                      || (rec_i > `CSE_EPAS_LIM));
        end
    end

    // Enable sequencer: start costs two clocks, stop waits for idle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st_q     <= CSE_OFF;
            active_q <= 1'b0;
        end else if (soft_rst_i) begin
            st_q     <= CSE_OFF;
            active_q <= 1'b0;
        end else begin
            active_q <= (st_q == CSE_WAKE2)
                        || (st_q == CSE_RUN && (run_ctl_i || !idle));
            case (st_q)
                CSE_OFF:   st_q <= run_ctl_i ? CSE_WAKE1 : CSE_OFF;
                CSE_WAKE1: st_q <= CSE_WAKE2;
                CSE_WAKE2: st_q <= CSE_RUN;
                CSE_RUN: begin
                    if (!run_ctl_i && idle) begin
                        st_q <= CSE_OFF;
                    end
                end
                default:   st_q <= CSE_OFF;
            endcase
        end
    end

    // Active flop loads the state being entered, so no extra lag
    assign active_o = active_q;

    // Stuff check: count equal raw bits inside stuffed fields
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            run_cnt_q <= 3'h0;
            run_bit_q <= 1'b1;
        end else if (!bits_i.stuff_zone) begin
            run_cnt_q <= 3'h0;
            run_bit_q <= 1'b1;
        end else if (bits_i.raw_vld) begin
            if (bits_i.raw_bit == run_bit_q &&
                run_cnt_q != 3'h0) begin
                run_cnt_q <= run_cnt_q + 3'h1;
            end else begin
                run_cnt_q <= 3'h1;
            end
            run_bit_q <= bits_i.raw_bit;
        end
    end
    // Sixth equal bit in a row is the violation
    assign stf_ev = bits_i.stuff_zone && bits_i.raw_vld
                    && bits_i.raw_bit == run_bit_q
                    && run_cnt_q == `CSE_STUFF_MAX;

    // CRC-15 over destuffed SOF..data, received field shifted aside
    assign crc_next = {crc_calc_q[13:0], 1'b0}
                      ^ ((bits_i.crc_bit ^ crc_calc_q[14])
                         ? `CSE_CRC_POLY : 15'h0000);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            crc_calc_q <= `CSE_CRC_INIT;
            crc_rcv_q  <= `CSE_CRC_INIT;
        end else if (bits_i.crc_done) begin
            crc_calc_q <= `CSE_CRC_INIT;
            crc_rcv_q  <= `CSE_CRC_INIT;
        end else begin
            if (bits_i.crc_vld) begin
                crc_calc_q <= crc_next;
            end
            if (bits_i.crcf_vld) begin
                crc_rcv_q <= {crc_rcv_q[13:0], bits_i.crc_bit};
            end
        end
    end
    assign crc_ev = bits_i.crc_done
                    && (crc_calc_q != crc_rcv_q);

    // Fixed fields must be recessive, ack slot must see dominant
    assign frm_ev = bits_i.fixed_fld && bits_i.raw_vld
                    && !bits_i.raw_bit;
    assign ack_ev = bits_i.ack_slot && bits_i.raw_vld
                    && bits_i.raw_bit;

    // Timer wrap and buffer full edges
    assign tim_ev = (tim_prev_q == `CSE_TIM_MAX)
                    && (can_timer_i == `CSE_TIM_ZERO);
    assign buf_ev = buf_full_i && !buf_prev_q;
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tim_prev_q <= `CSE_TIM_ZERO;
            buf_prev_q <= 1'b0;
        end else begin
            tim_prev_q <= can_timer_i;
            buf_prev_q <= buf_full_i;
        end
    end

    // Sticky flags: write 0 clears, write 1 keeps, an event wins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            tim_q <= 1'b0;
            buf_q <= 1'b0;
            stf_q <= 1'b0;
            crc_q <= 1'b0;
            frm_q <= 1'b0;
            ack_q <= 1'b0;
        end else if (soft_rst_i) begin
            tim_q <= 1'b0;
            buf_q <= 1'b0;
            stf_q <= 1'b0;
            crc_q <= 1'b0;
            frm_q <= 1'b0;
            ack_q <= 1'b0;
        end else begin
            tim_q <= tim_ev || (tim_q && !(wr_git
                     && !sfr_wdata_i[`CSE_GIT_TIM]));
            buf_q <= buf_ev || (buf_q && !(wr_git
                     && !sfr_wdata_i[`CSE_GIT_BUF]));
            stf_q <= stf_ev || (stf_q && !(wr_git
                     && !sfr_wdata_i[3]));
            crc_q <= crc_ev || (crc_q && !(wr_git
                     && !sfr_wdata_i[2]));
            frm_q <= frm_ev || (frm_q && !(wr_git
                     && !sfr_wdata_i[1]));
            ack_q <= ack_ev || (ack_q && !(wr_git
                     && !sfr_wdata_i[0]));
        end
    end

    // Mask register, reserved bits 7, 6 and 0 not stored
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            gie_q <= 5'h00;
        end else if (soft_rst_i) begin
            gie_q <= 5'h00;
        end else if (sfr_wr_i && sfr_addr_i == `CSE_ADR_GIE) begin
            gie_q <= sfr_wdata_i[5:1];
        end
    end

    // Object bits change only through a control rewrite or a soft reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            obj_q <= 4'h0;
        end else if (soft_rst_i) begin
            obj_q <= 4'h0;
        end else begin
            obj_q <= (obj_q & ~obj_wr_i)
                     | (obj_en_i & obj_wr_i);
        end
    end
    assign obj_active_o = obj_q;

    // Combined request; status-only bits never enter it
    assign irq_d = (gie_q[`CSE_GIE_RX] && rx_src_i)
                || (gie_q[`CSE_GIE_TX] && tx_src_i)
                || (gie_q[`CSE_GIE_OBJ] && obj_src_i)
                || (gie_q[`CSE_GIE_BUF] && buf_q)
                || (gie_q[`CSE_GIE_ERR]
                    && (stf_q || crc_q || frm_q || ack_q))
                || (tim_irq_on_i && tim_q);
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end
    assign irq_o = irq_q;

    // Read mux, registered; reserved and unmapped read zero
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rdata_q <= `CSE_RST_BYTE;
        end else if (sfr_rd_i) begin
            case (sfr_addr_i)
                `CSE_ADR_GIT:  rdata_q <= {irq_q, 1'b0, tim_q, buf_q,
                                   stf_q, crc_q, frm_q, ack_q};
                `CSE_ADR_TEC:  rdata_q <= tec_q;
                `CSE_ADR_REC:  rdata_q <= rec_q;
                `CSE_ADR_GSTA: rdata_q <= {1'b0, ovl_q, 1'b0, txa_q,
                                   rxa_q, active_o, bus_off_state_q,
                                   epas_q};
                `CSE_ADR_GIE:  rdata_q <= {2'b00, gie_q, 1'b0};
                `CSE_ADR_EN:   rdata_q <= {4'h0, obj_q};
                default:       rdata_q <= `CSE_RST_BYTE;
            endcase
        end
    end
    assign sfr_rdata_o = rdata_q;

    // Checks on the behaviour above
    sequence start_s;
        st_q == CSE_OFF && run_ctl_i;
    endsequence
    sequence stop_s;
        st_q == CSE_RUN && !run_ctl_i && idle;
    endsequence

    wake_delay_a: assert property (@(posedge clk_i)
        disable iff (rst_i || soft_rst_i)
        start_s |=> !active_o ##1 !active_o ##1 active_o)
        else $error("active not after two wake clocks");
    stop_freeze_a: assert property (@(posedge clk_i)
        disable iff (rst_i || soft_rst_i)
        (active_o && !idle) |=> active_o)
        else $error("engine stopped during a frame");
    stop_done_a: assert property (@(posedge clk_i)
        disable iff (rst_i || soft_rst_i)
        stop_s |=> !active_o)
        else $error("active stayed after stop");
    txbusy_ifs_a: assert property (@(posedge clk_i)
        disable iff (rst_i || soft_rst_i)
        (act_i.ifs && act_i.tx_pending) |=> txa_q)
        else $error("tx busy missing in pending spacing");
    ovl_track_a: assert property (@(posedge clk_i)
        disable iff (rst_i || soft_rst_i)
        !$past(soft_rst_i) |-> ovl_q == $past(act_i.overload_tx))
        else $error("overload bit out of step");
    status_ro_a: assert property (@(posedge clk_i)
        disable iff (rst_i || soft_rst_i)
        (sfr_wr_i && sfr_addr_i == `CSE_ADR_GSTA && idle
         && !act_i.tx_pending && !act_i.ifs)
        |=> !txa_q && !rxa_q && !ovl_q)
        else $error("status changed by a write");
    tim_set_a: assert property (@(posedge clk_i)
        disable iff (rst_i || soft_rst_i)
        tim_ev |=> tim_q)
        else $error("timer wrap not flagged");
    stuff_set_a: assert property (@(posedge clk_i)
        disable iff (rst_i || soft_rst_i)
        stf_ev |=> stf_q ##1 (stf_q || $past(wr_git)))
        else $error("stuff error not latched");
    flag_hold_a: assert property (@(posedge clk_i)
        disable iff (rst_i || soft_rst_i)
        (ack_q && !wr_git) |=> ack_q)
        else $error("ack error dropped without write");
    irq_err_a: assert property (@(posedge clk_i)
        disable iff (rst_i || soft_rst_i)
        (gie_q[`CSE_GIE_ERR] && crc_q) |=> irq_q)
        else $error("crc error not requesting irq");
    irq_tim_a: assert property (@(posedge clk_i)
        disable iff (rst_i || soft_rst_i)
        (!tim_irq_on_i && !(|gie_q)) |=> !irq_q)
        else $error("irq raised with all sources off");
    obj_keep_a: assert property (@(posedge clk_i)
        disable iff (rst_i || soft_rst_i)
        (obj_wr_i == 4'h0) |=> $stable(obj_q))
        else $error("object bit moved without rewrite");

endmodule // cse_status_regs

// *** verif/cse_can_node.sv ***
// Behavioural far-side node that feeds bit stream taps to the status set
`timescale 1ns/100ps
module cse_can_node
    import cse_pkg::*;
(
    input  wire logic       clk_i,  // Controller clock
    input  wire logic       rst_i,  // Async reset, high
    input  wire logic       go_i,   // Start one pattern
    input  wire logic [1:0] kind_i, // 0 stuff 1 form 2 ack 3 crc
    input  wire logic       bad_i,  // Break the pattern on purpose
    output cse_bits_type    bits_o, // Bit stream taps
    output logic            busy_o  // Pattern running
);
    logic [4:0] step_q;
    logic [1:0] kind_q;
    logic       bad_q;
    logic       tog_q;
    logic [4:0] last;

    // Pattern length per kind
    assign last = (kind_q == 2'h3) ? 5'h13 :
                  (kind_q == 2'h0) ? 5'h05 : 5'h00;

    // One bus bit per cycle; idle value flips so nothing stale is seen
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            busy_o <= 1'b0;
            step_q <= 5'h00;
            kind_q <= 2'h0;
            bad_q  <= 1'b0;
            tog_q  <= 1'b0;
        end else begin
            tog_q <= ~tog_q;
            if (go_i && !busy_o) begin
                busy_o <= 1'b1;
                step_q <= 5'h00;
                kind_q <= kind_i;
                bad_q  <= bad_i;
            end else if (busy_o) begin
                step_q <= step_q + 5'h01;
                busy_o <= (step_q != last);
            end
        end
    end

    // Taps; an all-zero payload has an all-zero CRC, so zeros are correct
    always_comb begin
        bits_o = '0;
        bits_o.raw_bit = tog_q;
        if (busy_o) begin
            case (kind_q)
                2'h0: begin
                    bits_o.raw_vld    = 1'b1;
                    bits_o.stuff_zone = 1'b1;
                    bits_o.raw_bit    = (step_q == 5'h05) && !bad_q;
                end
                2'h1: begin
                    bits_o.raw_vld   = 1'b1;
                    bits_o.fixed_fld = 1'b1;
                    bits_o.raw_bit   = !bad_q;
                end
                2'h2: begin
                    bits_o.raw_vld  = 1'b1;
                    bits_o.ack_slot = 1'b1;
                    bits_o.raw_bit  = bad_q;
                end
                default: begin
                    bits_o.crc_vld  = (step_q < 5'h04);
                    bits_o.crcf_vld = (step_q >= 5'h04) && (step_q < 5'h13);
                    bits_o.crc_bit  = bad_q && (step_q == 5'h12);
                    bits_o.crc_done = (step_q == 5'h13);
                end
            endcase
        end
    end
endmodule // cse_can_node

// *** verif/can_status_error_irq_regs_bench.sv ***
// Self-checking bench for the CAN status, error and irq mask registers
`timescale 1ns/100ps
`include "cse_map.svh"
module can_status_error_irq_regs_bench;
    import cse_pkg::*;
    // Flag of each error pattern: stuff, form, ack, crc
    localparam logic [7:0] ERR_BIT [4] = '{8'h08, 8'h02, 8'h01, 8'h04};
    logic         clk_i        = 1'b0;
    logic         rst_i        = 1'b1;
    logic         soft_rst_i   = 1'b0;
    logic [7:0]   sfr_addr_i   = 8'h00;
    logic         sfr_wr_i     = 1'b0;
    logic         sfr_rd_i     = 1'b0;
    logic [7:0]   sfr_wdata_i  = 8'h00;
    logic         run_ctl_i    = 1'b0;
    cse_act_type  act_i        = '0;
    logic [7:0]   tec_i        = 8'h00;
    logic [7:0]   rec_i        = 8'h00;
    logic         bus_off_i    = 1'b0;
    logic [15:0]  can_timer_i  = 16'h0000;
    logic         tim_irq_on_i = 1'b0;
    logic         buf_full_i   = 1'b0;
    logic         rx_src_i     = 1'b0;
    logic         tx_src_i     = 1'b0;
    logic         obj_src_i    = 1'b0;
    logic [3:0]   obj_wr_i     = 4'h0;
    logic [3:0]   obj_en_i     = 4'h0;
    logic         go           = 1'b0;
    logic [1:0]   kind         = 2'h0;
    logic         bad          = 1'b0;
    cse_bits_type bits_i;
    logic [7:0]   sfr_rdata_o;
    logic         irq_o;
    logic         active_o;
    logic         busy;
    logic [3:0]   obj_active_o;
    logic [7:0]   gie;
    logic [7:0]   ev;
    logic [3:0]   oen;
    int           failures     = 0;
    int           n_compared   = 0;

    cse_status_regs i_cse_status_regs (.clk_i, .rst_i, .soft_rst_i,
        .sfr_addr_i, .sfr_wr_i, .sfr_rd_i, .sfr_wdata_i, .sfr_rdata_o,
        .run_ctl_i, .act_i, .bits_i, .tec_i, .rec_i, .bus_off_i,
        .can_timer_i, .tim_irq_on_i, .buf_full_i, .rx_src_i, .tx_src_i,
        .obj_src_i, .obj_wr_i, .obj_en_i, .irq_o, .active_o, .obj_active_o);
    cse_can_node i_cse_can_node (.clk_i, .rst_i, .go_i(go), .kind_i(kind),
        .bad_i(bad), .bits_o(bits_i), .busy_o(busy));

    // 250 MHz controller clock
    initial begin
        forever #2 clk_i = ~clk_i;
    end

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // Strobe is dropped and a cycle passes, so calls may follow at once
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        sfr_addr_i  = a;
        sfr_wdata_i = d;
        sfr_wr_i    = 1'b1;
        tick();
        sfr_wr_i = 1'b0;
        tick();
    endtask

    task automatic rc(input logic [7:0] a, input logic [7:0] e,
                      input string nm);
        sfr_addr_i = a;
        sfr_rd_i   = 1'b1;
        tick();
        sfr_rd_i = 1'b0;
        chk(nm, sfr_rdata_o, e);
        tick();
    endtask

    task automatic frame(input logic [1:0] kd, input logic bd);
        go   = 1'b1;
        kind = kd;
        bad  = bd;
        tick();
        go = 1'b0;
        for (int w = 0; w < 30 && busy; w++) tick();
        chk("node done", 8'(busy), 8'h00);
    endtask

    // Status byte worked out from the activity levels now driven
    function automatic logic [7:0] exp_sta(input logic on);
        exp_sta    = 8'h00;
        exp_sta[6] = act_i.overload_tx;
        exp_sta[4] = act_i.frame_tx | act_i.ack_tx | act_i.overload_tx
                   | (act_i.ifs & act_i.tx_pending);
        exp_sta[3] = act_i.frame_rx;
        exp_sta[2] = on;
        exp_sta[1] = bus_off_i;
        exp_sta[0] = ((tec_i > 8'h7f) | (rec_i > 8'h7f)) & ~bus_off_i;
    endfunction

    function automatic logic exp_irq(input logic [7:0] g, input logic [7:0] f);
        return (g[5] & rx_src_i) | (g[4] & tx_src_i) | (g[3] & obj_src_i)
             | (g[2] & f[4]) | (g[1] & (|f[3:0])) | (tim_irq_on_i & f[5]);
    endfunction

    task automatic results();
        if (failures == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Watchdog, well beyond the few hundred cycles the tests need
    initial begin
        #40000;
        failures++;
        results();
    end

    initial begin
        void'($urandom(32'h7878));
        repeat (4) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        tick();
        rc(`CSE_ADR_GIT, 8'h00, "git reset");
        rc(`CSE_ADR_TEC, 8'h00, "tec reset");
        rc(`CSE_ADR_REC, 8'h00, "rec reset");
        rc(`CSE_ADR_GSTA, 8'h00, "gsta reset");
        rc(`CSE_ADR_GIE, 8'h00, "gie reset");
        rc(`CSE_ADR_EN, 8'h00, "obj reset");
        rc(8'h55, 8'h00, "unmapped");
        // Random activity and counters, first two on the passive boundary
        for (int i = 0; i < 16; i++) begin
            act_i     = cse_act_type'(6'($urandom));
            tec_i     = 8'($urandom);
            rec_i     = 8'($urandom);
            bus_off_i = 1'($urandom);
            if (i < 2) begin
                act_i     = '0;
                tec_i     = 8'h7f + 8'(i);
                rec_i     = 8'h00;
                bus_off_i = 1'b0;
            end
            wr(`CSE_ADR_GSTA, 8'($urandom) & 8'h5f);
            rc(`CSE_ADR_GSTA, exp_sta(1'b0),
               "gsta");
            rc(`CSE_ADR_TEC, tec_i, "tec");
            rc(`CSE_ADR_REC, rec_i, "rec");
        end
        act_i = '0;
        // Enable takes two cycles before the state shows
        run_ctl_i = 1'b1;
        tick();
        chk("active c1", 8'(active_o), 8'h00);
        tick();
        chk("active c2", 8'(active_o), 8'h00);
        tick();
        chk("active c3", 8'(active_o), 8'h01);
        rc(`CSE_ADR_GSTA, exp_sta(1'b1), "gsta on");
        // Disable in mid-frame: runs on until the frame ends
        act_i.frame_rx = 1'b1;
        tick();
        run_ctl_i = 1'b0;
        repeat (4) tick();
        chk("active frame", 8'(active_o), 8'h01);
        act_i = '0;
        repeat (2) tick();
        chk("active off", 8'(active_o), 8'h00);
        rc(`CSE_ADR_GSTA, exp_sta(1'b0), "gsta off");
        // Timer wrap and buffer full with every enable off
        buf_full_i  = 1'b1;
        can_timer_i = 16'hfffe;
        tick();
        buf_full_i  = 1'b0;
        can_timer_i = `CSE_TIM_MAX;
        tick();
        can_timer_i = `CSE_TIM_ZERO;
        repeat (3) tick();
        chk("irq masked", 8'(irq_o), 8'h00);
        rc(`CSE_ADR_GIT, 8'h30, "git wrap");
        // Random masks and sources against the combined request
        for (int i = 0; i < 12; i++) begin
            gie = 8'($urandom) & 8'h3e;
            if (i == 0) gie = 8'h3e;
            {rx_src_i, tx_src_i, obj_src_i, tim_irq_on_i} = 4'($urandom);
            wr(`CSE_ADR_GIE, gie);
            repeat (2) tick();
            ev = {7'h00, exp_irq(gie, 8'h30)};
            chk("irq", 8'(irq_o), ev);
            rc(`CSE_ADR_GIE, gie, "gie");
            rc(`CSE_ADR_GIT, {ev[0], 7'h30}, "git irq");
        end
        {rx_src_i, tx_src_i, obj_src_i, tim_irq_on_i} = 4'h0;
        wr(`CSE_ADR_GIT, 8'h20);
        rc(`CSE_ADR_GIT, 8'h20, "git buf clr");
        wr(`CSE_ADR_GIT, 8'h00);
        rc(`CSE_ADR_GIT, 8'h00, "git tim clr");
        // Each error pattern clean, then broken
        wr(`CSE_ADR_GIE, 8'h02);
        for (int k = 0; k < 8; k++) begin
            frame(2'(k >> 1), 1'(k));
            repeat (3) tick();
            ev = k[0] ? (ERR_BIT[k >> 1] | 8'h80) : 8'h00;
            rc(`CSE_ADR_GIT, ev,
               "git err");
            chk("irq err", 8'(irq_o), 8'(k[0]));
            wr(`CSE_ADR_GIT, 8'h00);
            repeat (2) tick();
            chk("irq clr", 8'(irq_o), 8'h00);
        end
        // Object enables: set by control rewrites, own writes ignored
        oen      = 4'($urandom) | 4'h1;
        obj_en_i = oen;
        obj_wr_i = 4'hf;
        tick();
        obj_wr_i = 4'h0;
        tick();
        chk("obj", 8'(obj_active_o), 8'(oen));
        wr(`CSE_ADR_EN, 8'h00);
        rc(`CSE_ADR_EN, 8'(oen), "obj ro");
        obj_en_i = 4'h0;
        obj_wr_i = 4'h1;
        tick();
        obj_wr_i = 4'h0;
        tick();
        chk("obj clr", 8'(obj_active_o), 8'(oen & 4'he));
        // General software reset clears mask and objects
        wr(`CSE_ADR_GIE, 8'h3e);
        soft_rst_i = 1'b1;
        tick();
        soft_rst_i = 1'b0;
        tick();
        rc(`CSE_ADR_GIE, 8'h00, "gie soft");
        rc(`CSE_ADR_EN, 8'h00, "obj soft");
        results();
    end
endmodule // can_status_error_irq_regs_bench
